//--- shared/ocs_pkg.sv
// shared constants for the optical switch control and status registers
package ocs_pkg;
	localparam int          ADDR_W          = 10;
	localparam int          DATA_W          = 16;
	localparam int          RELAY_WORDS     = 5;
	localparam int          SETTLE_BITS     = 6;
	localparam int          OPT_MODS        = 4;
	localparam int          TIMER_W         = 32;
	// byte offsets inside the module space
	localparam logic [9:0]  OFF_RELAY_LAST  = 10'h008;
	localparam logic [9:0]  OFF_SETTLE      = 10'h03E;
	localparam logic [9:0]  OFF_CONTROL     = 10'h100;
	localparam logic [9:0]  OFF_DELAY       = 10'h102;
	localparam logic [9:0]  OFF_HEALTH      = 10'h104;
	localparam logic [9:0]  OFF_COMMAND     = 10'h106;
	// values
	localparam logic [15:0] ALL_ONES        = 16'hFFFF;
	localparam logic [15:0] CTL_RESET       = 16'h0000;
	localparam logic [15:0] CTL_WMASK       = 16'hF3F8;
	localparam logic [15:0] DELAY_RESET     = 16'h0000;
	localparam logic [15:0] CMD_RESET       = 16'h0000;
	localparam logic [15:0] RELAY0_UNUSED   = 16'hF000;
	localparam logic [2:0]  HW_REV_DEFAULT  = 3'h1;
	// control fields
	localparam int          CTL_RST_LO      = 12;
	localparam int          CTL_INV         = 9;
	localparam int          CTL_ACF_OFF     = 8;
	localparam int          CTL_SEQ_EN      = 7;
	localparam int          CTL_MAKE_FIRST  = 6;
	localparam int          CTL_LED_FAIL    = 5;
	localparam int          CTL_OB_EN       = 4;
	localparam int          CTL_OB_SEL      = 3;
	// settle, health and command fields
	localparam int          SETTLE_SLOT     = 6;
	localparam int          HEALTH_REV_LO   = 13;
	localparam int          HEALTH_COMM_LO  = 4;
	localparam int          CMD_CNT_LO      = 12;
	// delay timer: one delay unit is one tick
	localparam int          CLK_NS          = 10;
	localparam int          DELAY_TICK_NS   = 1000;
	localparam int          DELAY_TICK_CYC  =
		(DELAY_TICK_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_INITIAL,
		SEQ_FINAL
	} ocs_seq_type;
endpackage

//--- design/ocs_countdown.sv
// loadable down-counter used as the relay sequencing delay timer
`timescale 1ns/1ns
module ocs_countdown #(
	parameter int W = 32
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic      [W-1:0] count,
	output logic              expire
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	assign nxt_cnt = load ? load_val :
		(cnt_ff != '0) ? cnt_ff - {{(W-1){1'b0}}, 1'b1} : '0;
	// expiry must not look at load: the owner builds load from expire,
	// so gating here would close a combinational loop
	assign expire = cnt_ff == {{(W-1){1'b0}}, 1'b1};
	assign count = cnt_ff;

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end
endmodule

//--- design/ocs_in_reg.sv
// register stage for level inputs from the plug-in side
`timescale 1ns/1ns
module ocs_in_reg #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] q_ff;

	assign dout = q_ff;

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			q_ff <= '0;
		else
			q_ff <= din;
	end
endmodule

//--- design/ocs_regs_top.sv
// control and status register bank of the optical switch controller
//
// Contract
// - settle register upper bits read ones
// - settle bit 6 reports single or double slot
// - low six settle bits show relays moving
// - reserved locations ignore writes, read all ones
// - control bits 15-12 hold optical modules reset
// - bit 9 inverts relay readback only
// - bit 8 low lets ac-fail reset relays
// - bit 7 low drives relay data directly
// - writes during initial delay restart timer
// - final closure timed, writes refused, busy held
// - unloaded delay register means no sequencing
// - open-bus resets relays only with bits 4,3
// - status bits 7-4 show communication errors
// - status bits 3-0 follow module error outputs
`timescale 1ns/1ns
module ocs_regs_top
	import ocs_pkg::*;
#(
	parameter logic [2:0] HW_REV = HW_REV_DEFAULT  // arbitrary value
) (
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	input  wire logic                          bus_sel,
	input  wire logic                          bus_wr,
	input  wire logic [ADDR_W-1:0]             bus_addr,
	input  wire logic [DATA_W-1:0]             bus_wdata,
	output logic      [DATA_W-1:0]             bus_rdata,
	output logic                               bus_ack,
	output logic                               bus_err,
	input  wire logic                          ac_fail_reset_input,
	input  wire logic                          open_bus_line,
	input  wire logic                          double_slot,
	input  wire logic [SETTLE_BITS-1:0]        relay_moving,
	input  wire logic [OPT_MODS-1:0]           opt_comm_err,
	input  wire logic [OPT_MODS-1:0]           opt_err,
	output logic      [RELAY_WORDS-1:0][15:0]  relay_drive,
	output logic      [OPT_MODS-1:0]           opt_module_reset,
	output logic                               access_led_fail,
	output logic      [3:0]                    cmd_read_count,
	output logic      [11:0]                   cmd_code,
	output logic                               cmd_strobe
);
	////////////////////////////////////////////////////////////////////
	// state
	logic [15:0]                  ctl_ff;
	logic [15:0]                  delay_ff;
	logic                         delay_loaded_ff;
	logic [15:0]                  cmd_ff;
	logic                         cmd_strobe_ff;
	logic [RELAY_WORDS-1:0][15:0] target_ff;
	logic [RELAY_WORDS-1:0][15:0] drive_ff;
	logic [RELAY_WORDS-1:0]       dirty_ff;
	logic [15:0]                  rdata_ff;
	logic                         ack_ff;
	logic                         err_ff;
	ocs_seq_type                  state_ff;
	ocs_seq_type                  nxt_state;

	logic [SETTLE_BITS-1:0]       moving_q;
	logic [OPT_MODS-1:0]          comm_q;
	logic [OPT_MODS-1:0]          err_q;
	logic                         slot_q;

	////////////////////////////////////////////////////////////////////
	// input stages
	ocs_in_reg #(.W(SETTLE_BITS + 2*OPT_MODS + 1)) u_in (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.din     ({relay_moving, opt_comm_err, opt_err, double_slot}),
		.dout    ({moving_q, comm_q, err_q, slot_q})
	);

	////////////////////////////////////////////////////////////////////
	// decode
	wire        wr_cyc     = bus_sel && bus_wr;
	wire        rd_cyc     = bus_sel && !bus_wr;
	wire [2:0]  relay_idx  = bus_addr[3:1];
	wire        hit_relay  = (bus_addr <= OFF_RELAY_LAST) && !bus_addr[0];
	wire        hit_settle = bus_addr == OFF_SETTLE;
	wire        hit_ctl    = bus_addr == OFF_CONTROL;
	wire        hit_delay  = bus_addr == OFF_DELAY;
	wire        hit_health = bus_addr == OFF_HEALTH;
	wire        hit_cmd    = bus_addr == OFF_COMMAND;
	wire        relay_wr   = wr_cyc && hit_relay;
	wire        seq_on     = ctl_ff[CTL_SEQ_EN] && delay_loaded_ff;
	wire        refuse     = relay_wr && (state_ff == SEQ_FINAL);
	wire        seq_wr     = relay_wr && seq_on && !refuse;
	wire        direct_wr  = relay_wr && !seq_on && !refuse;
	wire        acf_clear  = ac_fail_reset_input && !ctl_ff[CTL_ACF_OFF];
	wire        ob_clear   = open_bus_line && ctl_ff[CTL_OB_EN]
		&& ctl_ff[CTL_OB_SEL];
	wire        relay_clr  = acf_clear || ob_clear;
	wire [15:0] wr_word    = (relay_idx == 3'h0) ?
		(bus_wdata & ~RELAY0_UNUSED) : bus_wdata;
	wire        make_first = ctl_ff[CTL_MAKE_FIRST];

	////////////////////////////////////////////////////////////////////
	// delay timer
	logic [TIMER_W-1:0] tmr_count;
	logic               tmr_expire;
	wire  [TIMER_W-1:0] delay_cyc = TIMER_W'(delay_ff)
		* TIMER_W'(DELAY_TICK_CYC);
	wire                init_done = tmr_expire && (state_ff == SEQ_INITIAL);
	wire                final_done = tmr_expire && (state_ff == SEQ_FINAL);
	wire                tmr_load = (seq_wr || init_done) && !relay_clr;

	ocs_countdown #(.W(TIMER_W)) u_tmr (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.load     (tmr_load),
		.load_val (delay_cyc),
		.count    (tmr_count),
		.expire   (tmr_expire)
	);

	////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SEQ_IDLE: begin
				if (seq_wr)
					nxt_state = SEQ_INITIAL;
			end
			SEQ_INITIAL: begin
				if (init_done && !seq_wr)
					nxt_state = SEQ_FINAL;
			end
			SEQ_FINAL: begin
				if (final_done)
					nxt_state = SEQ_IDLE;
			end
			default: nxt_state = SEQ_IDLE;
		endcase
		if (relay_clr)
			nxt_state = SEQ_IDLE;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			state_ff <= SEQ_IDLE;
		else
			state_ff <= nxt_state;
	end

	////////////////////////////////////////////////////////////////////
	// relay words: break-first keeps only paths in both, make-first both
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			target_ff <= '0;
			drive_ff <= '0;
			dirty_ff <= '0;
		end else if (relay_clr) begin
			target_ff <= '0;
			drive_ff <= '0;
			dirty_ff <= '0;
		end else begin
			if (direct_wr) begin
				target_ff[relay_idx] <= wr_word;
				drive_ff[relay_idx] <= wr_word;
			end
			if (seq_wr) begin
				target_ff[relay_idx] <= wr_word;
				dirty_ff[relay_idx] <= 1'b1;
				drive_ff[relay_idx] <= make_first ?
					(drive_ff[relay_idx] | wr_word) :
					(drive_ff[relay_idx] & wr_word);
			end
			if (init_done && !seq_wr)
				drive_ff <= target_ff;
			if (final_done)
				dirty_ff <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctl_ff <= CTL_RESET;
			delay_ff <= DELAY_RESET;
			delay_loaded_ff <= 1'b0;
			cmd_ff <= CMD_RESET;
			cmd_strobe_ff <= 1'b0;
		end else begin
			cmd_strobe_ff <= wr_cyc && hit_cmd;
			if (wr_cyc && hit_ctl)
				ctl_ff <= bus_wdata & CTL_WMASK;
			if (wr_cyc && hit_delay) begin
				delay_ff <= bus_wdata;
				delay_loaded_ff <= 1'b1;
			end
			if (wr_cyc && hit_cmd)
				cmd_ff <= bus_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read path; settle and health are read-only, writes fall through
	wire [SETTLE_BITS-1:0] settle_w = moving_q
		| {1'b0, dirty_ff};
	wire [15:0] settle_rd = {9'h1FF, slot_q, settle_w};
	wire [15:0] health_rd = {HW_REV, 5'h00, comm_q, err_q};
	wire [15:0] relay_raw = target_ff[relay_idx]
		^ {16{ctl_ff[CTL_INV]}};
	wire [15:0] relay_rd  = (relay_idx == 3'h0) ?
		(relay_raw | RELAY0_UNUSED) : relay_raw;
	wire [15:0] rd_mux =
		hit_relay  ? relay_rd  :
		hit_settle ? settle_rd :
		hit_ctl    ? ctl_ff    :
		hit_delay  ? delay_ff  :
		hit_health ? health_rd :
		ALL_ONES;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata_ff <= ALL_ONES;
			ack_ff <= 1'b0;
			err_ff <= 1'b0;
		end else begin
			ack_ff <= bus_sel;
			err_ff <= refuse;
			if (rd_cyc)
				rdata_ff <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs
	assign bus_rdata        = rdata_ff;
	assign bus_ack          = ack_ff;
	assign bus_err          = err_ff;
	assign relay_drive      = drive_ff;
	assign opt_module_reset = ctl_ff[CTL_RST_LO +: OPT_MODS];
	assign access_led_fail  = ctl_ff[CTL_LED_FAIL];
	assign cmd_read_count   = cmd_ff[CMD_CNT_LO +: 4];
	assign cmd_code         = cmd_ff[11:0];
	assign cmd_strobe       = cmd_strobe_ff;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_seq_write;
		relay_wr && seq_on && (state_ff != SEQ_FINAL) && !relay_clr;
	endsequence

	sequence s_final_write;
		relay_wr && (state_ff == SEQ_FINAL);
	endsequence

	AST_SETTLE_TOP: assert property (
		rd_cyc && hit_settle |=> bus_rdata[15:7] == 9'h1FF)
		else $error("settle upper bits not ones");

	AST_SETTLE_SLOT: assert property (
		rd_cyc && hit_settle |=> bus_rdata[SETTLE_SLOT] == $past(slot_q))
		else $error("slot bit wrong");

	AST_SETTLE_BUSY: assert property (
		rd_cyc && hit_settle
		|=> bus_rdata[5:0] == $past(moving_q | {1'b0, dirty_ff}))
		else $error("settle bits wrong");

	AST_RSVD_READ: assert property (
		rd_cyc && !hit_relay && !hit_settle && !hit_ctl && !hit_delay
		&& !hit_health |=> bus_rdata == ALL_ONES)
		else $error("reserved read not all ones");

	AST_MOD_RESET: assert property (
		wr_cyc && hit_ctl
		|=> opt_module_reset == $past(bus_wdata[15:12]))
		else $error("module reset not from control write");

	AST_INV_CTL: assert property (
		rd_cyc && hit_ctl |=> bus_rdata == $past(ctl_ff))
		else $error("control readback altered");

	AST_ACF_CLEAR: assert property (
		ac_fail_reset_input && !ctl_ff[CTL_ACF_OFF]
		|=> relay_drive == '0 && dirty_ff == '0)
		else $error("ac-fail did not clear relays");

	AST_DIRECT: assert property (
		relay_wr && !seq_on && state_ff == SEQ_IDLE && !relay_clr
		|=> relay_drive[$past(relay_idx)] == $past(wr_word))
		else $error("direct relay write not applied");

	AST_RESTART: assert property (
		s_seq_write |=> tmr_count == $past(delay_cyc)
		&& state_ff == SEQ_INITIAL)
		else $error("timer not restarted");

	AST_REFUSE: assert property (
		s_final_write |=> bus_err && $stable(target_ff))
		else $error("write during final closure taken");

	AST_OPENBUS: assert property (
		open_bus_line && !(ctl_ff[CTL_OB_EN] && ctl_ff[CTL_OB_SEL])
		&& !acf_clear && relay_drive != '0 && !relay_wr
		&& state_ff == SEQ_IDLE |=> relay_drive == $past(relay_drive))
		else $error("open-bus cleared without enable");

	AST_RO_WRITE: assert property (
		wr_cyc && (hit_settle || hit_health)
		|=> $stable(ctl_ff) && $stable(delay_ff) && $stable(cmd_ff))
		else $error("read-only write changed state");
endmodule

//--- verif/ocs_far_model.sv
// far-side model: plug-in relay feedback and optical module status lines
`timescale 1ns/1ns
module ocs_far_model
	import ocs_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire logic [SETTLE_BITS-1:0] mov_cmd,
	input  wire logic [7:0]             err_cmd,
	output logic      [SETTLE_BITS-1:0] relay_moving,
	output logic      [OPT_MODS-1:0]    opt_comm_err,
	output logic      [OPT_MODS-1:0]    opt_err
);
////////////////////////////////////////////////////////////////////////////////
// one stage stands for the module's own reporting latency, so the bench
// cannot rely on a same-cycle status change
always_ff @(posedge sys_clk) begin
	if (!rst_n) begin
		relay_moving <= '0;
		opt_comm_err <= '0;
		opt_err      <= '0;
	end else begin
		relay_moving <= mov_cmd;
		opt_comm_err <= err_cmd[7:4];
		opt_err      <= err_cmd[3:0];
	end
end
endmodule

//--- verif/tb_optical_switch_control_status_regs.sv
// self-checking bench for the control and status register bank
`timescale 1ns/1ns
module tb_optical_switch_control_status_regs
	import ocs_pkg::*;
;
logic                         sys_clk, rst_n, bus_sel, bus_wr, bus_ack;
logic                         bus_err, ac_f, ob_l, dslot, led, stb, er;
logic [ADDR_W-1:0]            bus_addr;
logic [15:0]                  bus_wdata, bus_rdata, rd, v, w;
logic [5:0]                   mov, relay_moving;
logic [7:0]                   em;
logic [3:0]                   comm_e, opt_e, omr, cnt;
logic [11:0]                  code;
logic                         strobe;
logic [RELAY_WORDS-1:0][15:0] relay_drive;
logic [31:0]                  rnd;
int                           err_total, comparisons;
localparam logic [9:0]        RSV [5] = '{10'h040, 10'h0FE, 10'h200,
	10'h3FE, 10'h101};
ocs_regs_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_sel(bus_sel),
	.bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
	.bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
	.ac_fail_reset_input(ac_f), .open_bus_line(ob_l), .double_slot(dslot),
	.relay_moving(relay_moving), .opt_comm_err(comm_e), .opt_err(opt_e),
	.relay_drive(relay_drive), .opt_module_reset(omr),
	.access_led_fail(led), .cmd_read_count(cnt), .cmd_code(code),
	.cmd_strobe(strobe));
ocs_far_model far (.sys_clk(sys_clk), .rst_n(rst_n), .mov_cmd(mov),
	.err_cmd(em), .relay_moving(relay_moving), .opt_comm_err(comm_e),
	.opt_err(opt_e));
////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] nx(input logic [31:0] s);
	return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
// word 0 keeps only twelve relays; its top nibble reads as ones
function automatic logic [15:0] rbk(input int i, input logic [15:0] d,
	input logic inv);
	logic [15:0] t;
	t = d ^ {16{inv}};
	if (i == 0) t[15:12] = 4'hF;
	return t;
endfunction
task automatic chk(input string nm, input logic [15:0] seen,
	input logic [15:0] exp);
	comparisons++;
	if (seen !== exp) begin
		err_total++;
		$display("BAD %s exp %h got %h", nm, exp, seen);
	end
endtask
task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d);
	@(negedge sys_clk);
	bus_sel = 1'b1;
	bus_wr = wr;
	bus_addr = a;
	bus_wdata = d;
	@(negedge sys_clk);
	bus_sel = 1'b0;
	rd = bus_rdata;
	er = bus_err;
	stb = strobe;
	chk("ack", {15'h0000, bus_ack}, 16'h0001);
endtask
task automatic final_report();
	if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
	else $display("CHECKS NOT OK");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	sys_clk = 1'b0;
	forever #5 sys_clk = ~sys_clk;
end
initial begin
	#200000;
	err_total++;
	final_report();
end
initial begin
	{rst_n, bus_sel, bus_wr, ac_f, ob_l, dslot} = '0;
	{bus_addr, bus_wdata, mov, em} = '0;
	rnd = 32'h00001E1D;
	repeat (5) @(negedge sys_clk);
	rst_n = 1'b1;
	bus(1'b0, OFF_CONTROL, 16'h0000);
	chk("ctl_rst", rd, CTL_RESET);
	bus(1'b0, OFF_HEALTH, 16'h0000);
	chk("hlth_rst", rd, {HW_REV_DEFAULT, 13'h0000});
	for (int n = 0; n < 20; n++) begin
		rnd = nx(nx(rnd));
		{dslot, em, mov} = rnd[14:0];
		repeat (3) @(negedge sys_clk);
		bus(1'b0, OFF_SETTLE, 16'h0000);
		chk("settle", rd, {9'h1FF, dslot, mov});
		bus(1'b1, OFF_SETTLE, rnd[31:16]);
		bus(1'b1, OFF_HEALTH, rnd[31:16]);
		bus(1'b0, OFF_HEALTH, 16'h0000);
		chk("health", rd, {HW_REV_DEFAULT, 5'h00, em});
		w = rnd[31:16] & 16'hFF3F;
		bus(1'b1, OFF_CONTROL, w);
		bus(1'b0, OFF_CONTROL, 16'h0000);
		chk("ctl", rd, w & CTL_WMASK);
		chk("mreset", {12'h000, omr}, {12'h000, w[15:12]});
		chk("led", {15'h0000, led}, {15'h0000, w[CTL_LED_FAIL]});
		bus(1'b1, RSV[n % 5], rnd[15:0]);
		bus(1'b0, RSV[n % 5], 16'h0000);
		chk("rsvd", rd, ALL_ONES);
		v = {{1'b0, rnd[14:12]} + 4'h1, rnd[11:0]};
		bus(1'b1, OFF_COMMAND, v);
		chk("cmd", {cnt, code}, v);
		chk("cmd_stb", {15'h0000, stb}, 16'h0001);
		for (int i = 0; i < RELAY_WORDS; i++) begin
			rnd = nx(rnd);
			v = rnd[15:0];
			bus(1'b1, 10'(2 * i), v);
			@(negedge sys_clk);
			chk("drive", relay_drive[i], (i == 0) ? {4'h0, v[11:0]} : v);
			bus(1'b0, 10'(2 * i), 16'h0000);
			chk("relay_rb", rd, rbk(i, v, w[CTL_INV]));
		end
	end
	mov = '0;
	// ac-fail gating: blocked with bit 8 set, clears relays with it low
	bus(1'b1, OFF_CONTROL, 16'h0100);
	bus(1'b1, 10'h002, 16'hA5A5);
	ac_f = 1'b1;
	repeat (3) @(negedge sys_clk);
	chk("acf_off", relay_drive[1], 16'hA5A5);
	bus(1'b1, OFF_CONTROL, 16'h0000);
	repeat (3) @(negedge sys_clk);
	chk("acf_on", relay_drive[1], 16'h0000);
	ac_f = 1'b0;
	// open-bus reset needs both enable and select
	bus(1'b1, 10'h004, 16'h5A5A);
	bus(1'b1, OFF_CONTROL, 16'h0010);
	ob_l = 1'b1;
	repeat (3) @(negedge sys_clk);
	chk("ob_one", relay_drive[2], 16'h5A5A);
	bus(1'b1, OFF_CONTROL, 16'h0018);
	repeat (3) @(negedge sys_clk);
	chk("ob_both", relay_drive[2], 16'h0000);
	ob_l = 1'b0;
	// sequencing enabled with the delay never loaded acts immediately
	bus(1'b1, OFF_CONTROL, 16'h0080);
	bus(1'b1, 10'h004, 16'h00FF);
	@(negedge sys_clk);
	chk("seq_unl", relay_drive[2], 16'h00FF);
	bus(1'b1, OFF_DELAY, 16'h0001);
	bus(1'b1, 10'h004, 16'h0F0F);
	@(negedge sys_clk);
	chk("break", relay_drive[2], 16'h000F);
	bus(1'b0, OFF_SETTLE, 16'h0000);
	chk("busy", {15'h0000, rd[2]}, 16'h0001);
	repeat (DELAY_TICK_CYC - 40) @(negedge sys_clk);
	bus(1'b1, 10'h004, 16'h3C3C);
	chk("restart1", {15'h0000, er}, 16'h0000);
	repeat (DELAY_TICK_CYC - 40) @(negedge sys_clk);
	bus(1'b1, 10'h004, 16'h3C3C);
	chk("restart2", {15'h0000, er}, 16'h0000);
	repeat (DELAY_TICK_CYC + 30) @(negedge sys_clk);
	chk("final_drv", relay_drive[2], 16'h3C3C);
	bus(1'b1, 10'h004, 16'hFFFF);
	chk("refuse", {15'h0000, er}, 16'h0001);
	bus(1'b0, OFF_SETTLE, 16'h0000);
	chk("fin_busy", {15'h0000, rd[2]}, 16'h0001);
	repeat (DELAY_TICK_CYC + 20) @(negedge sys_clk);
	bus(1'b0, OFF_SETTLE, 16'h0000);
	chk("idle", {15'h0000, rd[2]}, 16'h0000);
	bus(1'b0, 10'h004, 16'h0000);
	chk("kept", rd, 16'h3C3C);
	final_report();
end
endmodule
